// ==== src/vmdma_map.svh ====
// offsets, word ids and constants for the vector memory dma setup block
`ifndef VMDMA_MAP_SVH
`define VMDMA_MAP_SVH
`define VMDMA_ADDR_W 4
`define VMDMA_OFF_STORE_PORT 4'h0
`define VMDMA_OFF_LOAD_PORT 4'h1
`define VMDMA_OFF_STORE_BASIC 4'h2
`define VMDMA_OFF_STORE_STRIDE 4'h3
`define VMDMA_OFF_LOAD_BASIC 4'h4
`define VMDMA_OFF_LOAD_XPITCH 4'h5
`define VMDMA_OFF_STORE_ROWS 4'h6
`define VMDMA_OFF_STORE_LOAD_ROW_LENGTH 4'h7
`define VMDMA_OFF_STORE_PITCH 4'h8
`define VMDMA_OFF_LOAD_ROWS 4'h9
`define VMDMA_OFF_LOAD_LOAD_ROW_LENGTH 4'hA
`define VMDMA_OFF_LOAD_PITCH 4'hB
`define VMDMA_OFF_LOAD_STEP 4'hC
`define VMDMA_OFF_LOAD_NEXT 4'hD
`define VMDMA_OFF_STATUS 4'hE
`define VMDMA_ST_ID_BASIC 2'h2
`define VMDMA_ST_ID_STRIDE 2'h3
`define VMDMA_LD_ID_XPITCH 4'h9
`define VMDMA_LD_MODE_XPITCH 3'h1
`define VMDMA_RESET_WORD 32'h00000000
`endif

// ==== src/vmdma_pkg.sv ====
// types for the vector memory dma setup block
package vmdma_pkg;
    typedef enum logic [1:0] {
        VMDMA_W32 = 2'h0,
        VMDMA_W16 = 2'h1,
        VMDMA_W8 = 2'h2,
        VMDMA_WBAD = 2'h3
    } vmdma_width_t;
endpackage : vmdma_pkg

// ==== src/vmdma_setup.sv ====
// setup decode and load row address stepping for the vector memory dma
`timescale 1ns/100ps
`default_nettype none
`include "vmdma_map.svh"
// How it works
// RULE1 - store word id 2 is basic setup
// RULE2 - store rows field, zero means 128
// RULE3 - store row length field, zero means 128
// RULE4 - bit 14 orientation; bit 15 written zero
// RULE5 - store start address is Y7 above X4
// RULE6 - store width mode decode with sub-offsets
// RULE7 - store word id 3 is stride setup
// RULE8 - bit 16 selects packed row stepping
// RULE9 - store gap between rows in bytes
// RULE10 - load bit31 set, mode not 1: basic
// RULE11 - load width mode decode, 1 is extended
// RULE12 - load pitch 8 shl exponent, zero uses bytes
// RULE13 - load row length, zero means 16
// RULE14 - load row count, zero means 16
// RULE15 - add row step to Y and sub-select
// RULE16 - row step position depends on width
// RULE17 - load orientation polarity opposite to store
// RULE18 - load start address is Y6 above X4
// RULE19 - load word id 9 is extended pitch
// RULE20 - extended byte pitch used when exponent zero
// RULE21 - each format held until rewritten
module vmdma_setup (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`VMDMA_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic store_valid,
    output logic [7:0] store_row_count,
    output logic [7:0] store_row_length,
    output logic store_horizontal,
    output logic [10:0] store_pipe_mem_start,
    output logic [1:0] store_width,
    output logic [1:0] store_sub_offset,
    output logic pack_rows_select,
    output logic [12:0] store_row_gap,
    output logic load_valid,
    output logic [1:0] load_width,
    output logic [18:0] load_pitch_bytes,
    output logic [4:0] load_row_length,
    output logic [4:0] load_row_count,
    output logic [4:0] pipe_mem_row_step,
    output logic load_vertical,
    output logic [10:0] load_pipe_mem_start,
    output logic setup_error
);
    logic [31:0] store_basic;
    logic [31:0] store_stride;
    logic [31:0] load_basic;
    logic [31:0] load_xpitch;
    logic [9:0] load_next;
    // byte or half-word select of the current load row, stepped with Y
    logic [1:0] load_sub;
    logic [1:0] next_load_sub;
    logic [3:0] sum_w8;
    logic [3:0] sum_w16;
    logic [3:0] sum_w32;
    logic st_wr;
    logic ld_wr;
    logic st_basic_hit;
    logic st_stride_hit;
    logic ld_basic_hit;
    logic ld_xpitch_hit;
    logic [2:0] st_mode;
    logic [2:0] ld_mode;
    logic [3:0] ld_exp;
    logic [12:0] xpitch_bytes;
    logic [4:0] step;
    logic [9:0] next_load_next;
    logic [31:0] next_rdata;

    assign st_wr = reg_wr && (reg_addr == `VMDMA_OFF_STORE_PORT);
    assign ld_wr = reg_wr && (reg_addr == `VMDMA_OFF_LOAD_PORT);
    assign st_basic_hit = st_wr && (reg_wdata[31:30] == `VMDMA_ST_ID_BASIC); // RULE1
    assign st_stride_hit = st_wr && (reg_wdata[31:30] == `VMDMA_ST_ID_STRIDE); // RULE7
    assign ld_basic_hit = ld_wr && reg_wdata[31] && (reg_wdata[30:28] != `VMDMA_LD_MODE_XPITCH); // RULE10
    assign ld_xpitch_hit = ld_wr && (reg_wdata[31:28] == `VMDMA_LD_ID_XPITCH); // RULE19

    // each format has its own holding register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            store_basic <= `VMDMA_RESET_WORD;
            store_stride <= `VMDMA_RESET_WORD;
            load_basic <= `VMDMA_RESET_WORD;
            load_xpitch <= `VMDMA_RESET_WORD;
        end else begin
            if (st_basic_hit) begin
                store_basic <= reg_wdata; // RULE21
            end
            if (st_stride_hit) begin
                store_stride <= reg_wdata; // RULE21
            end
            if (ld_basic_hit) begin
                load_basic <= reg_wdata; // RULE21
            end
            if (ld_xpitch_hit) begin
                load_xpitch <= reg_wdata; // RULE21
            end
        end
    end

    assign st_mode = store_basic[2:0];
    assign ld_mode = load_basic[30:28];
    assign ld_exp = load_basic[27:24];
    assign xpitch_bytes = load_xpitch[12:0];
    assign step = (load_basic[15:12] == 4'h0) ? 5'h10 : {1'b0, load_basic[15:12]}; // RULE15

    function automatic vmdma_pkg::vmdma_width_t vmdma_width(input logic [2:0] mode);
        if (mode[2]) begin
            vmdma_width = vmdma_pkg::VMDMA_W8;
        end else if (mode[1]) begin
            vmdma_width = vmdma_pkg::VMDMA_W16;
        end else if (mode[0]) begin
            vmdma_width = vmdma_pkg::VMDMA_WBAD;
        end else begin
            vmdma_width = vmdma_pkg::VMDMA_W32;
        end
    endfunction : vmdma_width

    // per-width row step sums; the sub-select is the low end of the stepped field
    // and its carry runs into Y, while higher Y bits and X never change
    assign sum_w8 = {load_next[5:4], load_sub} + step[3:0]; // RULE16
    assign sum_w16 = {load_next[6:4], load_sub[0]} + step[3:0]; // RULE16
    assign sum_w32 = load_next[7:4] + step[3:0]; // RULE16

    // running start of the next load row: {Y[5:0], X[3:0]} plus its sub-select
    always_comb begin
        next_load_next = load_next;
        next_load_sub = load_sub;
        if (ld_mode[2]) begin
            next_load_next[5:4] = sum_w8[3:2];
            next_load_sub = sum_w8[1:0];
        end else if (ld_mode[1]) begin
            next_load_next[6:4] = sum_w16[3:1];
            next_load_sub[0] = sum_w16[0];
        end else begin
            next_load_next[7:4] = sum_w32;
        end
    end

    // a basic load word restarts the walk; a write to the step index advances one row
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_next <= 10'h000;
            load_sub <= 2'h0;
        end else if (ld_basic_hit) begin
            load_next <= reg_wdata[9:0]; // RULE18
            load_sub <= reg_wdata[29:28]; // RULE16
        end else if (reg_wr && (reg_addr == `VMDMA_OFF_LOAD_STEP)) begin
            load_next <= next_load_next; // RULE15
            load_sub <= next_load_sub; // RULE15
        end
    end

    // decoded store outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            store_valid <= 1'b0;
            store_row_count <= 8'h00;
            store_row_length <= 8'h00;
            store_horizontal <= 1'b0;
            store_pipe_mem_start <= 11'h000;
            store_width <= 2'h0;
            store_sub_offset <= 2'h0;
            pack_rows_select <= 1'b0;
            store_row_gap <= 13'h0000;
        end else begin
            store_valid <= (store_basic[31:30] == `VMDMA_ST_ID_BASIC) && (st_mode != 3'h1);
            store_row_count <= (store_basic[29:23] == 7'h00) ? 8'h80 : {1'b0, store_basic[29:23]}; // RULE2
            store_row_length <= (store_basic[22:16] == 7'h00) ? 8'h80 : {1'b0, store_basic[22:16]}; // RULE3
            store_horizontal <= store_basic[14]; // RULE4
            store_pipe_mem_start <= store_basic[13:3]; // RULE5
            store_width <= vmdma_width(st_mode); // RULE6
            store_sub_offset <= st_mode[2] ? st_mode[1:0] : {1'b0, st_mode[1] & st_mode[0]}; // RULE6
            pack_rows_select <= store_stride[16]; // RULE8
            store_row_gap <= store_stride[12:0]; // RULE9
        end
    end

    // decoded load outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_valid <= 1'b0;
            load_width <= 2'h0;
            load_pitch_bytes <= 19'h00000;
            load_row_length <= 5'h00;
            load_row_count <= 5'h00;
            pipe_mem_row_step <= 5'h00;
            load_vertical <= 1'b0;
            load_pipe_mem_start <= 11'h000;
        end else begin
            load_valid <= load_basic[31] && (ld_mode != `VMDMA_LD_MODE_XPITCH);
            load_width <= vmdma_width(ld_mode); // RULE11
            if (ld_exp == 4'h0) begin
                load_pitch_bytes <= {6'h00, xpitch_bytes}; // RULE20
            end else begin
                // largest exponent gives 8 shl 15, which needs all 19 bits
                load_pitch_bytes <= 19'h00008 << ld_exp; // RULE12
            end
            load_row_length <= (load_basic[23:20] == 4'h0) ? 5'h10 : {1'b0, load_basic[23:20]}; // RULE13
            load_row_count <= (load_basic[19:16] == 4'h0) ? 5'h10 : {1'b0, load_basic[19:16]}; // RULE14
            pipe_mem_row_step <= step; // RULE15
            load_vertical <= load_basic[11]; // RULE17
            load_pipe_mem_start <= {1'b0, load_next}; // RULE18
        end
    end

    // bit 15 of a basic store word must be zero and store mode 1 is invalid; flag either violation
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            setup_error <= 1'b0;
        end else if (st_basic_hit) begin
            setup_error <= reg_wdata[15] || (reg_wdata[2:0] == 3'h1); // RULE4
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        unique case (reg_addr)
            `VMDMA_OFF_STORE_BASIC: next_rdata = store_basic;
            `VMDMA_OFF_STORE_STRIDE: next_rdata = store_stride;
            `VMDMA_OFF_LOAD_BASIC: next_rdata = load_basic;
            `VMDMA_OFF_LOAD_XPITCH: next_rdata = load_xpitch;
            `VMDMA_OFF_STORE_ROWS: next_rdata = {24'h000000, store_row_count};
            `VMDMA_OFF_STORE_LOAD_ROW_LENGTH: next_rdata = {24'h000000, store_row_length};
            `VMDMA_OFF_STORE_PITCH: next_rdata = {19'h00000, store_row_gap};
            `VMDMA_OFF_LOAD_ROWS: next_rdata = {27'h0000000, load_row_count};
            `VMDMA_OFF_LOAD_LOAD_ROW_LENGTH: next_rdata = {27'h0000000, load_row_length};
            `VMDMA_OFF_LOAD_PITCH: next_rdata = {13'h0000, load_pitch_bytes};
            `VMDMA_OFF_LOAD_NEXT: next_rdata = {20'h00000, load_sub, load_next};
            `VMDMA_OFF_STATUS: next_rdata = {29'h00000000, setup_error, load_valid, store_valid};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule : vmdma_setup
`default_nettype wire

// ==== testbench/vmdma_cpu_model.sv ====
// processor side model issuing setup port writes and register reads
`timescale 1ns/100ps
`default_nettype none
module vmdma_cpu_model (
    input wire logic core_clk,
    input wire logic [31:0] reg_rdata,
    output var logic [3:0] reg_addr,
    output var logic [31:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // released data lines do not keep the last word
        reg_wdata <= ~d;
    endtask : wr
    // two writes to one index on consecutive edges, strobe held high between them
    task automatic wr2(input logic [3:0] a, input logic [31:0] d0, input logic [31:0] d1);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d0;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wdata <= d1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d1;
    endtask : wr2
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : vmdma_cpu_model
`default_nettype wire

// ==== testbench/vmdma_setup_assertions.sv ====
// concurrent checks on the decoded setup outputs
`timescale 1ns/100ps
`default_nettype none
module vmdma_setup_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] store_row_count,
    input wire logic [7:0] store_row_length,
    input wire logic store_horizontal,
    input wire logic [10:0] store_pipe_mem_start,
    input wire logic [1:0] store_width,
    input wire logic pack_rows_select,
    input wire logic [12:0] store_row_gap,
    input wire logic [1:0] load_width,
    input wire logic [18:0] load_pitch_bytes,
    input wire logic [4:0] load_row_count,
    input wire logic load_vertical
);
    logic st_b, st_s, ld_b, ld_x;
    assign st_b = reg_wr && reg_addr == 4'h0 && reg_wdata[31:30] == 2'h2;
    assign st_s = reg_wr && reg_addr == 4'h0 && reg_wdata[31:30] == 2'h3;
    assign ld_b = reg_wr && reg_addr == 4'h1 && reg_wdata[31] && reg_wdata[30:28] != 3'h1;
    assign ld_x = reg_wr && reg_addr == 4'h1 && reg_wdata[31:28] == 4'h9;
    function automatic logic [1:0] wmap(input logic [2:0] m);
        return m[2] ? 2'h2 : m[1] ? 2'h1 : m[0] ? 2'h3 : 2'h0;
    endfunction : wmap
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    store_rows_a: assert property (st_b ##1 !reg_wr |-> ##1
        store_row_count == {~|$past(reg_wdata[29:23], 2), $past(reg_wdata[29:23], 2)}) else $error("store rows wrong");
    store_len_a: assert property (st_b ##1 !reg_wr |-> ##1
        store_row_length == {~|$past(reg_wdata[22:16], 2), $past(reg_wdata[22:16], 2)}) else $error("store length wrong");
    store_start_a: assert property (st_b ##1 !reg_wr |-> ##1
        {store_horizontal, store_pipe_mem_start} == $past(reg_wdata[14:3], 2)) else $error("store start wrong");
    store_width_a: assert property (st_b ##1 !reg_wr |-> ##1
        store_width == wmap($past(reg_wdata[2:0], 2))) else $error("store width wrong");
    store_stride_a: assert property (st_s ##1 !reg_wr |-> ##1
        {pack_rows_select, store_row_gap} == {$past(reg_wdata[16], 2), $past(reg_wdata[12:0], 2)}) else $error("stride wrong");
    load_fields_a: assert property (ld_b ##1 !reg_wr |-> ##1 load_vertical == $past(reg_wdata[11], 2) &&
        load_row_count == {~|$past(reg_wdata[19:16], 2), $past(reg_wdata[19:16], 2)}) else $error("load fields wrong");
    load_pitch_a: assert property (ld_b && reg_wdata[27:24] inside {[1:7]} ##1 !reg_wr |-> ##1
        load_pitch_bytes == 19'h8 << $past(reg_wdata[27:24], 2) && load_width == wmap($past(reg_wdata[30:28], 2)))
        else $error("load pitch wrong");
    ext_pitch_a: assert property (ld_x ##1 (ld_b && reg_wdata[27:24] == 4'h0) ##1 !reg_wr |-> ##1
        load_pitch_bytes == {6'h00, $past(reg_wdata[12:0], 3)}) else $error("byte pitch wrong");
endmodule : vmdma_setup_assertions
bind vmdma_setup vmdma_setup_assertions vmdma_setup_assertions_i (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .store_row_count(store_row_count),
    .store_row_length(store_row_length), .store_horizontal(store_horizontal),
    .store_pipe_mem_start(store_pipe_mem_start), .store_width(store_width), .pack_rows_select(pack_rows_select),
    .store_row_gap(store_row_gap), .load_width(load_width), .load_pitch_bytes(load_pitch_bytes),
    .load_row_count(load_row_count), .load_vertical(load_vertical));
`default_nettype wire

// ==== testbench/vmdma_setup_bench.sv ====
// self-checking bench for the setup decode block
`timescale 1ns/100ps
`default_nettype none
module vmdma_setup_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic reg_wr, reg_rd, store_valid, store_horizontal, pack_rows_select, load_valid, load_vertical, setup_error;
    logic [7:0] store_row_count, store_row_length;
    logic [10:0] store_pipe_mem_start, load_pipe_mem_start;
    logic [1:0] store_width, store_sub_offset, load_width;
    logic [12:0] store_row_gap;
    logic [18:0] load_pitch_bytes;
    logic [4:0] load_row_length, load_row_count, pipe_mem_row_step;
    int error_cnt = 0;
    int compares = 0;
    vmdma_cpu_model vmdma_cpu_model_i (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    vmdma_setup vmdma_setup_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_valid(store_valid),
        .store_row_count(store_row_count), .store_row_length(store_row_length), .store_horizontal(store_horizontal),
        .store_pipe_mem_start(store_pipe_mem_start), .store_width(store_width), .store_sub_offset(store_sub_offset),
        .pack_rows_select(pack_rows_select), .store_row_gap(store_row_gap), .load_valid(load_valid),
        .load_width(load_width), .load_pitch_bytes(load_pitch_bytes), .load_row_length(load_row_length),
        .load_row_count(load_row_count), .pipe_mem_row_step(pipe_mem_row_step), .load_vertical(load_vertical),
        .load_pipe_mem_start(load_pipe_mem_start), .setup_error(setup_error));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic put(input logic [3:0] a, input logic [31:0] d);
        vmdma_cpu_model_i.wr(a, d);
        repeat (2) @(posedge core_clk);
        #1;
    endtask : put
    task automatic print_verdict;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [1:0] wexp(input logic [2:0] m);
        return m[2] ? 2'h2 : m[1] ? 2'h1 : m[0] ? 2'h3 : 2'h0;
    endfunction : wexp
    initial forever #5 core_clk = ~core_clk;
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("store_valid", store_valid, 0);
        put(4'h0, 32'h80000000);
        chk("store_row_count", store_row_count, 8'h80);
        chk("store_row_length", store_row_length, 8'h80);
        chk("store_valid", store_valid, 1);
        for (int m = 0; m < 8; m++) begin
            put(4'h0, {2'h2, 7'h7F, 7'h01, 1'b0, 1'b1, 11'h5A5, 3'(m)});
            chk("store_width", store_width, wexp(3'(m)));
            chk("store_sub_offset", store_sub_offset, m[2] ? 32'(m[1:0]) : m[1] ? 32'(m[0]) : 32'h0);
            chk("setup_error", setup_error, m == 1);
        end
        chk("store_row_count", store_row_count, 8'h7F);
        chk("store_row_length", store_row_length, 8'h01);
        chk("store_start", {store_horizontal, store_pipe_mem_start}, 12'hDA5);
        put(4'h0, 32'h80008000);
        chk("setup_error", setup_error, 1);
        put(4'h0, 32'h7FFFFFFF);
        chk("store_row_count", store_row_count, 8'h80);
        put(4'h0, 32'hC0011FFF);
        chk("stride", {pack_rows_select, store_row_gap}, 14'h3FFF);
        put(4'h0, 32'h80000000);
        chk("pack_rows_select", pack_rows_select, 1);
        put(4'h0, 32'hC0000000);
        chk("stride", {pack_rows_select, store_row_gap}, 14'h0);
        for (int m = 0; m < 8; m++) begin
            if (m == 1) continue;
            put(4'h1, {1'b1, 3'(m), 4'h3, 12'h000, 1'b1, 11'h2A5});
            chk("load_width", load_width, wexp(3'(m)));
            chk("load_pitch_bytes", load_pitch_bytes, 16'h40);
            chk("load_lengths", {load_row_length, load_row_count, pipe_mem_row_step}, 15'h4210);
            chk("load_start", {load_vertical, load_pipe_mem_start}, 12'hAA5);
        end
        put(4'h1, 32'h82759013);
        chk("load_pitch_bytes", load_pitch_bytes, 16'h20);
        chk("load_lengths", {load_row_length, load_row_count, pipe_mem_row_step}, 15'h1CA9);
        put(4'hC, 32'h0);
        chk("load_pipe_mem_start", load_pipe_mem_start, 11'h0A3);
        // 8-bit: step 3 added to {Y[1:0], byte 2}
        put(4'h1, 32'hE1113013);
        put(4'hC, 32'h0);
        vmdma_cpu_model_i.rd(4'hD, rv);
        chk("load_step_w8", rv, 32'h423);
        // 16-bit: step 5 added to {Y[2:0], half 1}
        put(4'h1, 32'hB1115013);
        put(4'hC, 32'h0);
        chk("load_step_w16", load_pipe_mem_start, 11'h043);
        put(4'h1, 32'h90001234);
        put(4'h1, 32'h80000000);
        chk("load_pitch_bytes", load_pitch_bytes, 16'h1234);
        put(4'h1, 32'h0F000000);
        chk("load_pitch_bytes", load_pitch_bytes, 16'h1234);
        vmdma_cpu_model_i.wr2(4'h1, 32'h90000ABC, 32'h80000000);
        repeat (2) @(posedge core_clk);
        #1;
        chk("load_pitch_bytes", load_pitch_bytes, 16'h0ABC);
        put(4'h1, 32'h8F000000);
        chk("load_pitch_bytes", load_pitch_bytes, 32'h40000);
        put(4'h1, 32'h80000000);
        vmdma_cpu_model_i.rd(4'hE, rv);
        chk("status", rv, 32'h3);
        vmdma_cpu_model_i.rd(4'h2, rv);
        chk("store_basic_setup", rv, 32'h80000000);
        vmdma_cpu_model_i.rd(4'hF, rv);
        chk("unmapped", rv, 32'h0);
        print_verdict();
    end
endmodule : vmdma_setup_bench
`default_nettype wire
